// ---- design/cssr_pkg.sv ----
package cssr_pkg;

  localparam logic [15:0] CSSR_ADDR_ALARM_STATUS = 16'h0200;
  localparam logic [15:0] CSSR_ADDR_PLL_SEL_REF  = 16'h0205;
  localparam logic [15:0] CSSR_ADDR_GPI_LEVELS   = 16'h0219;
  localparam logic [15:0] CSSR_ADDR_BOOT_FAIL    = 16'h021e;
  localparam logic [15:0] CSSR_ADDR_EEP_STATUS   = 16'h021f;

  // Alarm status bit positions at the alarm status address.
  localparam int CSSR_ALARM_LOS0_BIT = 0;
  localparam int CSSR_ALARM_LOS1_BIT = 1;
  localparam int CSSR_ALARM_HOLD_BIT = 4;
  localparam int CSSR_ALARM_LOL_BIT  = 6;

  // Field positions inside the status bytes.
  localparam int CSSR_REF_CODE_LSB  = 0;
  localparam int CSSR_FB_LOST_BIT   = 4;
  localparam int CSSR_GPI_LSB       = 0;
  localparam int CSSR_INT_FLAG_BIT  = 0;
  localparam int CSSR_BOOT_FAIL_BIT = 4;
  localparam int CSSR_LOAD_DONE_BIT = 0;
  localparam int CSSR_CRC_OK_BIT    = 3;

  localparam logic [7:0] CSSR_ALARM_MASK  = 8'h53;
  localparam logic [7:0] CSSR_RDATA_RESET = 8'h00;

  typedef struct packed {
    logic [2:0] selected_reference_code;
    logic       feedback_signal_lost;
    logic [3:0] gpi_is_input;
    logic [7:0] alarm_event;
    logic [7:0] alarm_enable;
    logic       eeprom_read_fail;
    logic       eeprom_read_done;
    logic       eeprom_crc_fail;
  } cssr_core_status_s;

endpackage

// ---- design/cssr_status_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module cssr_status_regs
  import cssr_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic [15:0]       i_reg_addr,
  input  wire logic              i_reg_rd,
  input  wire logic              i_reg_wr,
  input  wire logic [7:0]        i_reg_wdata,
  input  wire cssr_core_status_s i_core,
  input  wire logic [3:0]        i_general_input_pin,
  output logic      [7:0]        o_reg_rdata,
  output logic                   o_reg_rvalid,
  output logic                   o_port_locked,
  output logic                   o_alarm_request_pin_low_out,
  output logic                   o_alarm_request_pin_low_oe_n
);

  logic [3:0] gpi_s1_reg;
  logic [3:0] gpi_s2_reg;
  logic [3:0] gpi_s3_reg;
  logic [3:0] gpi_value_reg;
  logic [7:0] alarm_reg;
  logic [7:0] alarm_next;
  logic [7:0] alarm_clear;
  logic       int_flag_reg;
  logic       boot_fail_reg;
  logic       load_done_reg;
  logic       crc_ok_reg;
  logic [7:0] rdata_next;
  logic       alarm_pending;

  // Pins are asynchronous; a level counts once the second and third agree.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      gpi_s1_reg    <= 4'h0;
      gpi_s2_reg    <= 4'h0;
      gpi_s3_reg    <= 4'h0;
      gpi_value_reg <= 4'h0;
    end else begin
      gpi_s1_reg <= i_general_input_pin;
      gpi_s2_reg <= gpi_s1_reg;
      gpi_s3_reg <= gpi_s2_reg;
      for (int i = 0; i < 4; i++) begin
        if (gpi_s2_reg[i] == gpi_s3_reg[i]) begin
          gpi_value_reg[i] <= gpi_s3_reg[i];
        end
      end
    end
  end

  // A locked port ignores writes, so clearing alarms is impossible then.
  assign alarm_clear = (i_reg_wr && !o_port_locked &&
                        i_reg_addr == CSSR_ADDR_ALARM_STATUS)
                       ? (i_reg_wdata & CSSR_ALARM_MASK) : 8'h00;
  // A new event wins over a clear in the same cycle.
  assign alarm_next  = (alarm_reg & ~alarm_clear)
                       | (i_core.alarm_event & CSSR_ALARM_MASK);

  // Set and enabled bits, shared by the flag, the pin and the checks.
  assign alarm_pending = |(alarm_reg & i_core.alarm_enable);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      alarm_reg <= 8'h00;
    end else begin
      alarm_reg <= alarm_next;
    end
  end

  // Open drain: the pin is only ever pulled low, never driven high.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      int_flag_reg                 <= 1'b0;
      o_alarm_request_pin_low_oe_n <= 1'b1;
      o_alarm_request_pin_low_out  <= 1'b0;
    end else begin
      int_flag_reg                 <= alarm_pending;
      o_alarm_request_pin_low_oe_n <= ~alarm_pending;
      o_alarm_request_pin_low_out  <= 1'b0;
    end
  end

  // Configuration load outcome; only a device reset returns these to their reset values.
  // The lock also shuts the alarm clear path, yet reads are still served.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      boot_fail_reg <= 1'b0;
      load_done_reg <= 1'b0;
      crc_ok_reg    <= 1'b1;
      o_port_locked <= 1'b0;
    end else begin
      if (i_core.eeprom_read_fail) begin
        boot_fail_reg <= 1'b1;
      end
      if (i_core.eeprom_read_done) begin
        load_done_reg <= 1'b1;
      end
      if (i_core.eeprom_crc_fail) begin
        crc_ok_reg    <= 1'b0;
        o_port_locked <= 1'b1;
      end
    end
  end

  // Reserved bits read as zero; software must not rely on them.
  always_comb begin
    rdata_next = 8'h00;
    unique case (i_reg_addr)
      CSSR_ADDR_ALARM_STATUS: rdata_next = alarm_reg;
      CSSR_ADDR_PLL_SEL_REF: begin
        rdata_next[CSSR_REF_CODE_LSB +: 3] =
          i_core.selected_reference_code;
        rdata_next[CSSR_FB_LOST_BIT] =
          i_core.feedback_signal_lost;
      end
      CSSR_ADDR_GPI_LEVELS: begin
        rdata_next[CSSR_GPI_LSB +: 4] =
          gpi_value_reg & i_core.gpi_is_input;
      end
      CSSR_ADDR_BOOT_FAIL: begin
        rdata_next[CSSR_INT_FLAG_BIT]  = int_flag_reg;
        rdata_next[CSSR_BOOT_FAIL_BIT] = boot_fail_reg;
      end
      CSSR_ADDR_EEP_STATUS: begin
        rdata_next[CSSR_LOAD_DONE_BIT] = load_done_reg;
        rdata_next[CSSR_CRC_OK_BIT]    = crc_ok_reg;
      end
      default: rdata_next = 8'h00;
    endcase
  end

  // Data reads zero outside a read, so a stale byte never looks fresh.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_reg_rdata  <= CSSR_RDATA_RESET;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      o_reg_rdata  <= i_reg_rd ? rdata_next : CSSR_RDATA_RESET;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  ref_code_read_a: assert property (
    i_reg_rd && i_reg_addr == CSSR_ADDR_PLL_SEL_REF
    |=> o_reg_rdata[CSSR_REF_CODE_LSB +: 3]
        == $past(i_core.selected_reference_code))
    else $error("reference code read mismatch");

  fb_lost_read_a: assert property (
    i_reg_rd && i_reg_addr == CSSR_ADDR_PLL_SEL_REF
    |=> o_reg_rdata[CSSR_FB_LOST_BIT] == $past(i_core.feedback_signal_lost))
    else $error("feedback lost read mismatch");

  // Five quiet cycles cover the three sync stages and the agreement flop.
  gpi_level_read_a: assert property (
    ($stable(i_general_input_pin) && $stable(i_core.gpi_is_input)) [*5]
    ##0 (i_reg_rd && i_reg_addr == CSSR_ADDR_GPI_LEVELS)
    |=> o_reg_rdata[CSSR_GPI_LSB +: 4]
        == ($past(i_general_input_pin) & $past(i_core.gpi_is_input)))
    else $error("input level read mismatch");

  irq_pin_level_a: assert property (
    ##1 o_alarm_request_pin_low_oe_n == !$past(alarm_pending)
        && int_flag_reg == !o_alarm_request_pin_low_oe_n)
    else $error("interrupt pin does not follow enabled status");

  boot_fail_hold_a: assert property (
    i_core.eeprom_read_fail |=> boot_fail_reg [*8])
    else $error("boot failure flag not held");

  load_done_hold_a: assert property (
    $rose(load_done_reg)
    |-> $past(i_core.eeprom_read_done) ##1 load_done_reg [*8])
    else $error("load complete flag not held");

  crc_lock_a: assert property (
    i_core.eeprom_crc_fail |=> !crc_ok_reg && o_port_locked)
    else $error("crc failure does not lock the port");

  // A write while locked must clear no alarm bit; only new events are added.
  locked_write_a: assert property (
    o_port_locked && i_reg_wr
    |=> alarm_reg == ($past(alarm_reg)
                      | ($past(i_core.alarm_event) & CSSR_ALARM_MASK)))
    else $error("write accepted while the port is locked");

  alarm_sticky_a: assert property (
    alarm_reg[CSSR_ALARM_LOL_BIT] && !alarm_clear[CSSR_ALARM_LOL_BIT]
    |=> alarm_reg[CSSR_ALARM_LOL_BIT])
    else $error("sticky alarm bit lost");

  // A clear that leaves no enabled bit set frees the pin two edges on.
  clear_release_a: assert property (
    alarm_clear != 8'h00 && (alarm_next & i_core.alarm_enable) == 8'h00
    ##1 $stable(i_core.alarm_enable)
    |=> o_alarm_request_pin_low_oe_n)
    else $error("clearing alarms did not release the pin");

  // Main scenarios that the bench is expected to reach.
  cover_irq_c:   cover property ($fell(o_alarm_request_pin_low_oe_n));
  cover_clear_c: cover property ($rose(o_alarm_request_pin_low_oe_n));
  cover_crc_c:   cover property ($rose(o_port_locked));
  cover_done_c:  cover property ($rose(load_done_reg) && crc_ok_reg);
  cover_gpi_c:   cover property (|gpi_value_reg);

endmodule
`default_nettype wire

// ---- verif/cssr_status_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module cssr_status_regs_tb import cssr_pkg::*;;
  logic              i_clock;
  logic              i_rst;
  logic [15:0]       addr;
  logic              rd;
  logic              wr;
  logic [7:0]        wdata;
  cssr_core_status_s core;
  logic [3:0]        pins;
  logic [7:0]        rdata;
  logic              rvalid;
  logic              locked;
  logic              pin_out;
  logic              pin_oe_n;
  int                errors;
  int                checked;

  cssr_status_regs i_cssr_status_regs (
    .i_clock                      (i_clock),
    .i_rst                        (i_rst),
    .i_reg_addr                   (addr),
    .i_reg_rd                     (rd),
    .i_reg_wr                     (wr),
    .i_reg_wdata                  (wdata),
    .i_core                       (core),
    .i_general_input_pin          (pins),
    .o_reg_rdata                  (rdata),
    .o_reg_rvalid                 (rvalid),
    .o_port_locked                (locked),
    .o_alarm_request_pin_low_out  (pin_out),
    .o_alarm_request_pin_low_oe_n (pin_oe_n)
  );

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The answer stands for one cycle only, so it is sampled one cycle on.
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(negedge i_clock);
    addr = a;
    rd = 1'b1;
    @(negedge i_clock);
    rd = 1'b0;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask

  task automatic wr_op(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clock);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge i_clock);
    wr = 1'b0;
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    errors = 0;
    checked = 0;
    i_rst = 1'b1;
    addr = 16'h0000;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 8'h00;
    core = '0;
    pins = 4'h0;
    tick(3);
    i_rst = 1'b0;
    rd_chk(CSSR_ADDR_EEP_STATUS, 8'h08);
    rd_chk(CSSR_ADDR_BOOT_FAIL, 8'h00);
    rd_chk(16'h0300, 8'h00);
    $display("Test reset values done");
    for (int c = 0; c < 6; c++) begin
      core.selected_reference_code = 3'(c);
      core.feedback_signal_lost = c[0];
      rd_chk(CSSR_ADDR_PLL_SEL_REF, {3'h0,c[0],1'b0,3'(c)});
    end
    pins = 4'ha;
    core.gpi_is_input = 4'h6;
    tick(6);
    rd_chk(CSSR_ADDR_GPI_LEVELS, 8'h02);
    $display("Test pll and inputs done");
    core.alarm_enable = 8'h40;
    core.alarm_event = 8'h41;
    tick(1);
    core.alarm_event = 8'h00;
    tick(2);
    chk({7'h00, pin_oe_n}, 8'h00);
    chk({7'h00, pin_out}, 8'h00);
    rd_chk(CSSR_ADDR_BOOT_FAIL, 8'h01);
    rd_chk(CSSR_ADDR_ALARM_STATUS, 8'h41);
    wr_op(CSSR_ADDR_ALARM_STATUS, 8'h40);
    tick(1);
    chk({7'h00, pin_oe_n}, 8'h01);
    rd_chk(CSSR_ADDR_ALARM_STATUS, 8'h01);
    $display("Test alarm summary done");
    core.eeprom_read_done = 1'b1;
    tick(1);
    core.eeprom_read_done = 1'b0;
    core.eeprom_read_fail = 1'b1;
    core.eeprom_crc_fail = 1'b1;
    tick(1);
    core.eeprom_read_fail = 1'b0;
    core.eeprom_crc_fail = 1'b0;
    tick(1);
    chk({7'h00, locked}, 8'h01);
    rd_chk(CSSR_ADDR_BOOT_FAIL, 8'h10);
    rd_chk(CSSR_ADDR_EEP_STATUS, 8'h01);
    wr_op(CSSR_ADDR_ALARM_STATUS, 8'h01);
    rd_chk(CSSR_ADDR_ALARM_STATUS, 8'h01);
    i_rst = 1'b1;
    tick(2);
    i_rst = 1'b0;
    chk({7'h00, locked}, 8'h00);
    rd_chk(CSSR_ADDR_EEP_STATUS, 8'h08);
    rd_chk(CSSR_ADDR_BOOT_FAIL, 8'h00);
    $display("Test eeprom outcome done");
    conclude();
  end
endmodule
`default_nettype wire
